// *** afe_path_gain_config_bank.sv ***
// configuration bank for the slot A path code, channel 2..4 gains, power-down and digital integration modes
//
// Contract
// (R1) Slot A path code is a 16-bit read-write register that resets to the full analog chain code 0xada5.
// (R2) Software writes 0xae65 or 0xb065 for amplifier-to-converter use by buffer bit state; other codes are reserved.
// (R3) Bits 15:13 of the gain register power down channels 2 to 4 in digital integration when set to 7.
// (R4) Slot B gain fields for channels 4, 3, 2 sit at bits 11:10, 9:8, 7:6 and reset to zero.
// (R5) Slot A gain fields for channels 4, 3, 2 sit at bits 5:4, 3:2, 1:0 and reset to zero.
// (R6) Gapped-mode bit 7 inserts a gap set by the active slot's fine offset, or no gap when clear.
// (R7) Bit 6 selects single sample pair for slot B when set and double pair when clear.
// (R8) Bit 5 selects single sample pair for slot A when set and double pair when clear.
// (R9) The slot A integrator becomes a buffer when its buffer bit is set or digital integration is chosen.
// (R10) Per-channel gains apply only while the slot's individual-gain enable is set, else the common gain.
// (R11) Reserved bits are written zero by software and are stored and returned unchanged.
`timescale 1ns/1ns
`include "afe_path_gain_defines.svh"

module afe_path_gain_config_bank (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire afe_path_gain_pkg::reg_req_t REG_REQ,
  output afe_path_gain_pkg::path_mode_t SLOT_A_PATH_MODE,
  output logic [15:0] REG_RDATA,
  output logic REG_RVALID,
  input wire logic SLOT_A_INTEGRATOR_BUFFER_SELECT,
  input wire logic SLOT_A_DIGITAL_INTEGRATE,
  input wire logic SLOT_B_DIGITAL_INTEGRATE,
  input wire logic SLOT_A_PER_CHANNEL_GAIN_ENABLE,
  input wire logic SLOT_B_PER_CHANNEL_GAIN_ENABLE,
  input wire afe_path_gain_pkg::gain_code_t SLOT_A_COMMON_GAIN,
  input wire afe_path_gain_pkg::gain_code_t SLOT_B_COMMON_GAIN,
  input wire logic [4:0] SLOT_A_WINDOW_FINE_OFFSET,
  input wire logic [4:0] SLOT_B_WINDOW_FINE_OFFSET,
  input wire logic ACTIVE_SLOT_B,
  output logic [15:0] SLOT_A_PATH_CODE,
  output afe_path_gain_pkg::chan_gains_t SLOT_A_GAINS,
  output afe_path_gain_pkg::chan_gains_t SLOT_B_GAINS,
  output logic PHOTODIODE_INPUT_TWO_POWERDOWN,
  output logic PHOTODIODE_INPUT_THREE_POWERDOWN,
  output logic PHOTODIODE_INPUT_FOUR_POWERDOWN,
  output logic SLOT_A_INTEGRATOR_AS_BUFFER,
  output logic [4:0] SAMPLE_GAP_US,
  output logic SLOT_A_SINGLE_PAIR,
  output logic SLOT_B_SINGLE_PAIR
);
  import afe_path_gain_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic path_mode_t decode_path(input logic [15:0] code);
    case (code)
      `CODE_FULL_ANALOG_CHAIN: decode_path = PATH_FULL_CHAIN;
      `CODE_AMP_CONV_BUFFERED: decode_path = PATH_AMP_CONV_BUFFERED;
      `CODE_AMP_CONV_UNBUFFERED: decode_path = PATH_AMP_CONV_UNBUFFERED;
      default: decode_path = PATH_RESERVED;
    endcase
  endfunction

  // per-channel field when individual gain is on, common gain otherwise
  function automatic chan_gains_t pick_gains(input logic ind_en, input gain_code_t common,
                                             input logic [5:0] per_chan);
    chan_gains_t g;
    g.ch1 = common;
    if (ind_en) begin
      g.ch4 = per_chan[5:4];
      g.ch3 = per_chan[3:2];
      g.ch2 = per_chan[1:0];
    end else begin
      g.ch4 = common;
      g.ch3 = common;
      g.ch2 = common;
    end
    pick_gains = g;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // register storage

  logic [15:0] path_connection;
  logic [15:0] gain_and_power;
  logic [15:0] integration_control;
  logic [15:0] next_path_connection;
  logic [15:0] next_gain_and_power;
  logic [15:0] next_integration_control;
  logic [15:0] next_rdata;
  logic next_rvalid;

  // whole words stored, reserved bits included, so they read back as written
  always_comb begin
    next_path_connection = path_connection;
    next_gain_and_power = gain_and_power;
    next_integration_control = integration_control;
    if (REG_REQ.wr) begin
      case (REG_REQ.addr)
        `ADDR_SLOT_A_PATH_CONNECTION: next_path_connection = REG_REQ.wdata; // R1 R2
        `ADDR_CHANNEL_GAIN_AND_POWER: next_gain_and_power = REG_REQ.wdata; // R3 R4 R5 R11
        `ADDR_DIGITAL_INTEGRATION_CONTROL: next_integration_control = REG_REQ.wdata; // R6 R7 R8 R11
        default: next_path_connection = path_connection;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      path_connection <= `RST_SLOT_A_PATH_CONNECTION; // R1
      gain_and_power <= `RST_CHANNEL_GAIN_AND_POWER; // R3 R4 R5
      integration_control <= `RST_DIGITAL_INTEGRATION_CONTROL; // R6 R7 R8
    end else begin
      path_connection <= next_path_connection;
      gain_and_power <= next_gain_and_power;
      integration_control <= next_integration_control;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read port: the answer stands for one cycle after the request is taken

  always_comb begin
    next_rvalid = REG_REQ.rd;
    next_rdata = 16'h0000;
    if (REG_REQ.rd) begin
      case (REG_REQ.addr)
        `ADDR_SLOT_A_PATH_CONNECTION: next_rdata = path_connection;
        `ADDR_CHANNEL_GAIN_AND_POWER: next_rdata = gain_and_power; // R11
        `ADDR_DIGITAL_INTEGRATION_CONTROL: next_rdata = integration_control; // R11
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      REG_RDATA <= 16'h0000;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RDATA <= next_rdata;
      REG_RVALID <= next_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // path code and integrator mode seen by the analog chain

  path_mode_t next_path_mode;
  logic next_buffer;

  always_comb begin
    next_path_mode = decode_path(path_connection); // R2
    next_buffer = SLOT_A_INTEGRATOR_BUFFER_SELECT | SLOT_A_DIGITAL_INTEGRATE; // R9
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      SLOT_A_PATH_MODE <= PATH_FULL_CHAIN;
      SLOT_A_PATH_CODE <= `RST_SLOT_A_PATH_CONNECTION;
      SLOT_A_INTEGRATOR_AS_BUFFER <= 1'b0;
    end else begin
      SLOT_A_PATH_MODE <= next_path_mode;
      SLOT_A_PATH_CODE <= path_connection; // R1
      SLOT_A_INTEGRATOR_AS_BUFFER <= next_buffer;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // effective channel gains and channel 2..4 power-down

  chan_gains_t next_a_gains;
  chan_gains_t next_b_gains;
  logic next_pd;
  logic any_digital;

  always_comb begin
    any_digital = SLOT_A_DIGITAL_INTEGRATE | SLOT_B_DIGITAL_INTEGRATE;
    next_a_gains = pick_gains(SLOT_A_PER_CHANNEL_GAIN_ENABLE, SLOT_A_COMMON_GAIN,
                              gain_and_power[`SLOT_A_CH4_GAIN_LSB+1:`SLOT_A_CH2_GAIN_LSB]); // R5 R10
    next_b_gains = pick_gains(SLOT_B_PER_CHANNEL_GAIN_ENABLE, SLOT_B_COMMON_GAIN,
                              gain_and_power[`SLOT_B_CH4_GAIN_LSB+1:`SLOT_B_CH2_GAIN_LSB]); // R4 R10
    // only the all-ones code powers down; other nonzero codes leave channels up
    next_pd = any_digital && (gain_and_power[`POWERDOWN_MSB:`POWERDOWN_LSB] == `POWERDOWN_ALL); // R3
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      SLOT_A_GAINS <= '0;
      SLOT_B_GAINS <= '0;
      PHOTODIODE_INPUT_TWO_POWERDOWN <= 1'b0;
      PHOTODIODE_INPUT_THREE_POWERDOWN <= 1'b0;
      PHOTODIODE_INPUT_FOUR_POWERDOWN <= 1'b0;
    end else begin
      SLOT_A_GAINS <= next_a_gains;
      SLOT_B_GAINS <= next_b_gains;
      PHOTODIODE_INPUT_TWO_POWERDOWN <= next_pd;
      PHOTODIODE_INPUT_THREE_POWERDOWN <= next_pd;
      PHOTODIODE_INPUT_FOUR_POWERDOWN <= next_pd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // digital integration gap and sample pair modes

  logic [4:0] next_gap;
  logic next_a_single;
  logic next_b_single;

  always_comb begin
    if (!integration_control[`GAPPED_SAMPLING_BIT]) begin
      next_gap = 5'h00; // R6
    end else if (ACTIVE_SLOT_B) begin
      next_gap = SLOT_B_WINDOW_FINE_OFFSET; // R6
    end else begin
      next_gap = SLOT_A_WINDOW_FINE_OFFSET; // R6
    end
    next_b_single = integration_control[`SLOT_B_PAIR_COUNT_BIT]; // R7
    next_a_single = integration_control[`SLOT_A_PAIR_COUNT_BIT]; // R8
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      SAMPLE_GAP_US <= 5'h00;
      SLOT_A_SINGLE_PAIR <= 1'b0;
      SLOT_B_SINGLE_PAIR <= 1'b0;
    end else begin
      SAMPLE_GAP_US <= next_gap;
      SLOT_A_SINGLE_PAIR <= next_a_single;
      SLOT_B_SINGLE_PAIR <= next_b_single;
    end
  end

endmodule // afe_path_gain_config_bank

// *** afe_path_gain_defines.svh ***
// register offsets, field positions, reset values and codes of the path and gain configuration bank
`ifndef AFE_PATH_GAIN_DEFINES_SVH
`define AFE_PATH_GAIN_DEFINES_SVH

`define ADDR_SLOT_A_PATH_CONNECTION 8'h43
`define ADDR_CHANNEL_GAIN_AND_POWER 8'h55
`define ADDR_DIGITAL_INTEGRATION_CONTROL 8'h5a

`define RST_SLOT_A_PATH_CONNECTION 16'hada5
`define RST_CHANNEL_GAIN_AND_POWER 16'h0000
`define RST_DIGITAL_INTEGRATION_CONTROL 16'h0000

`define CODE_FULL_ANALOG_CHAIN 16'hada5
`define CODE_AMP_CONV_BUFFERED 16'hae65
`define CODE_AMP_CONV_UNBUFFERED 16'hb065

`define POWERDOWN_MSB 15
`define POWERDOWN_LSB 13
`define POWERDOWN_ALL 3'h7
`define SLOT_B_CH4_GAIN_LSB 10
`define SLOT_B_CH3_GAIN_LSB 8
`define SLOT_B_CH2_GAIN_LSB 6
`define SLOT_A_CH4_GAIN_LSB 4
`define SLOT_A_CH3_GAIN_LSB 2
`define SLOT_A_CH2_GAIN_LSB 0

`define GAPPED_SAMPLING_BIT 7
`define SLOT_B_PAIR_COUNT_BIT 6
`define SLOT_A_PAIR_COUNT_BIT 5

`endif

// *** afe_path_gain_pkg.sv ***
// types shared by the path and gain configuration bank
package afe_path_gain_pkg;

  // 0: 200 kohm, 1: 100 kohm, 2: 50 kohm, 3: 25 kohm
  typedef logic [1:0] gain_code_t;

  typedef struct packed {
    gain_code_t ch4;
    gain_code_t ch3;
    gain_code_t ch2;
    gain_code_t ch1;
  } chan_gains_t;

  typedef enum logic [1:0] {
    PATH_FULL_CHAIN = 2'b00,
    PATH_AMP_CONV_BUFFERED = 2'b01,
    PATH_AMP_CONV_UNBUFFERED = 2'b10,
    PATH_RESERVED = 2'b11
  } path_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage

// *** afe_path_gain_checker.sv ***
// concurrent checks on the register port and control outputs of the path and gain bank
`timescale 1ns/1ns
module afe_path_gain_checker (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire afe_path_gain_pkg::reg_req_t REG_REQ,
  input wire logic [15:0] REG_RDATA,
  input wire logic REG_RVALID,
  input wire logic [15:0] SLOT_A_PATH_CODE,
  input wire afe_path_gain_pkg::path_mode_t SLOT_A_PATH_MODE,
  input wire logic SLOT_A_INTEGRATOR_BUFFER_SELECT,
  input wire logic SLOT_A_DIGITAL_INTEGRATE,
  input wire logic SLOT_B_DIGITAL_INTEGRATE,
  input wire logic PHOTODIODE_INPUT_TWO_POWERDOWN,
  input wire logic SLOT_A_INTEGRATOR_AS_BUFFER,
  input wire logic SLOT_A_SINGLE_PAIR,
  input wire logic SLOT_B_SINGLE_PAIR
);
  import afe_path_gain_pkg::*;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  ////////////////////////////////////////////////////////////
  // outputs lag the register by one edge, so a write shows two edges after it is taken
  read_valid_a: assert property (!$past(SYS_RST) |-> REG_RVALID == $past(REG_REQ.rd))
    else $error("read valid not one cycle after read");
  idle_data_a: assert property (!$past(SYS_RST) && !$past(REG_REQ.rd) |-> REG_RDATA == 16'h0000)
    else $error("read data not zero outside a read");
  path_write_a: assert property (REG_REQ.wr && REG_REQ.addr == 8'h43 |=> ##1 SLOT_A_PATH_CODE == $past(REG_REQ.wdata, 2))
    else $error("path code does not follow write");
  read_back_a: assert property (REG_REQ.wr && !REG_REQ.rd && REG_REQ.addr == 8'h43
    ##1 REG_REQ.rd && REG_REQ.addr == 8'h43 |=> REG_RDATA == $past(REG_REQ.wdata, 2))
    else $error("path read back differs");
  path_mode_a: assert property (SLOT_A_PATH_MODE == (SLOT_A_PATH_CODE == 16'hada5 ? PATH_FULL_CHAIN :
    SLOT_A_PATH_CODE == 16'hae65 ? PATH_AMP_CONV_BUFFERED : SLOT_A_PATH_CODE == 16'hb065 ? PATH_AMP_CONV_UNBUFFERED :
    PATH_RESERVED)) else $error("path mode decode wrong");
  pair_mode_a: assert property (REG_REQ.wr && REG_REQ.addr == 8'h5a |=> ##1 SLOT_A_SINGLE_PAIR == $past(REG_REQ.wdata[5], 2)
    && SLOT_B_SINGLE_PAIR == $past(REG_REQ.wdata[6], 2)) else $error("pair mode does not follow write");
  buffer_mode_a: assert property (!$past(SYS_RST) |-> SLOT_A_INTEGRATOR_AS_BUFFER ==
    ($past(SLOT_A_INTEGRATOR_BUFFER_SELECT) || $past(SLOT_A_DIGITAL_INTEGRATE))) else $error("buffer mode wrong");
  power_down_a: assert property (PHOTODIODE_INPUT_TWO_POWERDOWN |->
    $past(SLOT_A_DIGITAL_INTEGRATE) || $past(SLOT_B_DIGITAL_INTEGRATE)) else $error("power-down outside integration");
endmodule // afe_path_gain_checker
bind afe_path_gain_config_bank afe_path_gain_checker chk (.SYS_CLK, .SYS_RST, .REG_REQ, .REG_RDATA, .REG_RVALID,
  .SLOT_A_PATH_CODE, .SLOT_A_PATH_MODE, .SLOT_A_INTEGRATOR_BUFFER_SELECT, .SLOT_A_DIGITAL_INTEGRATE,
  .SLOT_B_DIGITAL_INTEGRATE, .PHOTODIODE_INPUT_TWO_POWERDOWN, .SLOT_A_INTEGRATOR_AS_BUFFER, .SLOT_A_SINGLE_PAIR,
  .SLOT_B_SINGLE_PAIR);

// *** testbench.sv ***
// self-checking testbench for the path and gain configuration bank
`timescale 1ns/1ns
module testbench;
  import afe_path_gain_pkg::*;
  typedef struct {logic [7:0] a; logic [15:0] d; logic [15:0] e;} row_t;
  logic SYS_CLK = 0, SYS_RST = 1, sel = 0, a_di = 0, b_di = 0, a_en = 0, b_en = 0, act_b = 0;
  gain_code_t a_com = 0, b_com = 0;
  logic [4:0] a_off = 0, b_off = 0, gap;
  reg_req_t req = '0;
  path_mode_t mode;
  logic [15:0] rdata, code;
  logic rvalid, a_buf, a_sp, b_sp, pd2, pd3, pd4;
  chan_gains_t a_g, b_g;
  int mismatches = 0, comparisons = 0;
  // last row is an unmapped place: the write must vanish and the read return zero
  row_t rows[6] = '{'{8'h43, 16'hae65, 16'hae65}, '{8'h43, 16'hb065, 16'hb065}, '{8'h43, 16'h1234, 16'h1234},
    '{8'h55, 16'hffff, 16'hffff}, '{8'h5a, 16'hffff, 16'hffff}, '{8'h77, 16'hffff, 16'h0000}};
  afe_path_gain_config_bank dut (.SYS_CLK, .SYS_RST, .REG_REQ(req), .SLOT_A_PATH_MODE(mode), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .SLOT_A_INTEGRATOR_BUFFER_SELECT(sel), .SLOT_A_DIGITAL_INTEGRATE(a_di),
    .SLOT_B_DIGITAL_INTEGRATE(b_di), .SLOT_A_PER_CHANNEL_GAIN_ENABLE(a_en), .SLOT_B_PER_CHANNEL_GAIN_ENABLE(b_en),
    .SLOT_A_COMMON_GAIN(a_com), .SLOT_B_COMMON_GAIN(b_com), .SLOT_A_WINDOW_FINE_OFFSET(a_off),
    .SLOT_B_WINDOW_FINE_OFFSET(b_off), .ACTIVE_SLOT_B(act_b), .SLOT_A_PATH_CODE(code), .SLOT_A_GAINS(a_g),
    .SLOT_B_GAINS(b_g), .PHOTODIODE_INPUT_TWO_POWERDOWN(pd2), .PHOTODIODE_INPUT_THREE_POWERDOWN(pd3),
    .PHOTODIODE_INPUT_FOUR_POWERDOWN(pd4), .SLOT_A_INTEGRATOR_AS_BUFFER(a_buf), .SAMPLE_GAP_US(gap),
    .SLOT_A_SINGLE_PAIR(a_sp), .SLOT_B_SINGLE_PAIR(b_sp));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // a write is left standing; the next task's first edge takes it
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge SYS_CLK);
    req <= '{a, d, 1'b1, 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge SYS_CLK);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge SYS_CLK);
    req <= '0;
    #1;
    chk(rvalid, 1'b1);
    chk(rdata, e);
  endtask
  task automatic look(input int n);
    repeat (n) begin
      @(posedge SYS_CLK);
      req <= '0;
    end
    #1;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    forever #25 SYS_CLK = ~SYS_CLK;
  end
  initial begin
    repeat (1000) @(posedge SYS_CLK);
    mismatches++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge SYS_CLK);
    SYS_RST <= 0;
    rd(8'h43, 16'hada5);
    rd(8'h55, 16'h0000);
    rd(8'h5a, 16'h0000);
    chk(code, 16'hada5);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    chk(mode, PATH_RESERVED);
    @(posedge SYS_CLK);
    {a_en, a_com, b_com, b_di, a_off, b_off} <= {1'b1, 2'h1, 2'h2, 1'b1, 5'h0a, 5'h15};
    wr(8'h55, 16'hee46);
    look(2);
    chk(a_g, 8'h19);
    chk(b_g, 8'haa);
    chk({pd2, pd3, pd4}, 3'h7);
    @(posedge SYS_CLK);
    {b_en, b_di, sel} <= 3'b101;
    look(1);
    chk(b_g, 8'he6);
    chk(a_buf, 1'b1);
    @(posedge SYS_CLK);
    {a_di, sel} <= 2'b10;
    wr(8'h55, 16'hc000);
    look(2);
    chk({pd2, pd3, pd4}, 3'h0);
    wr(8'h5a, 16'h0080);
    look(2);
    chk({gap, a_sp, b_sp}, {5'h0a, 2'b00});
    @(posedge SYS_CLK);
    act_b <= 1;
    wr(8'h5a, 16'h0060);
    look(1);
    chk(gap, 5'h15);
    look(1);
    chk({gap, a_sp, b_sp}, {5'h00, 2'b11});
    @(posedge SYS_CLK);
    SYS_RST <= 1;
    @(posedge SYS_CLK);
    SYS_RST <= 0;
    rd(8'h43, 16'hada5);
    rd(8'h5a, 16'h0000);
    conclude();
  end
endmodule // testbench
